// [dec_pkg.sv]
package dec_pkg;

	// Sizes
	localparam int NUM_CTR   = 2;
	localparam int CTR_W     = 40;
	localparam int LOAD_W    = 32;
	localparam int SEL_W     = 32;
	localparam int EXT_W     = CTR_W - LOAD_W;
	localparam int SIGN_BIT  = LOAD_W - 1;
	localparam int EVT_CNT_W = 8;
	localparam int IDX_W     = 2;

	// Model-register indexes
	localparam logic [IDX_W-1:0] IDX_SEL0 = 2'h0;
	localparam logic [IDX_W-1:0] IDX_SEL1 = 2'h1;
	localparam logic [IDX_W-1:0] IDX_CNT0 = 2'h2;
	localparam logic [IDX_W-1:0] IDX_CNT1 = 2'h3;

	// Privilege
	localparam logic [1:0] CPL_KERNEL = 2'h0;

	// Reset values and writable bits
	localparam logic [SEL_W-1:0] SEL_RESET  = 32'h00000000;
	localparam logic [CTR_W-1:0] CNT_RESET  = 40'h0000000000;
	localparam logic [SEL_W-1:0] SEL0_WMASK = 32'hFFDFFFFF;
	localparam logic [SEL_W-1:0] SEL1_WMASK = 32'hFF9FFFFF;
	localparam logic [EVT_CNT_W-1:0] EVT_ZERO = 8'h00;
	localparam logic [EVT_CNT_W-1:0] EVT_ONE  = 8'h01;
	localparam logic [EXT_W-1:0] READ_PAD     = 8'h00;

	typedef logic [CTR_W-1:0] dec_count_t;

	// Event-select layout, bit 31 down to bit 0
	typedef struct packed {
		logic [7:0] perCycleThreshold;
		logic       compareFlip;
		logic       globalRun;
		logic       reserved21;
		logic       overflowIrqEn;
		logic       pinModeSelect;
		logic       edgeDetect;
		logic       kernelLevelQualifier;
		logic       userLevelQualifier;
		logic [7:0] eventSubqualifier;
		logic [7:0] eventCode;
	} dec_evtsel_t;

	typedef struct packed {
		logic             valid;
		logic             write;
		logic [IDX_W-1:0] index;
		logic [LOAD_W-1:0] wdata;
	} dec_msr_req_t;

	typedef struct packed {
		logic       done;
		logic       fault;
		dec_count_t rdata;
	} dec_msr_rsp_t;

	typedef struct packed {
		logic [1:0] cpl;
		logic       v86;
	} dec_priv_t;

	typedef struct packed {
		logic valid;
		logic index;
	} dec_read_req_t;

	typedef struct packed {
		logic       done;
		logic       fault;
		dec_count_t data;
	} dec_read_rsp_t;

	typedef struct packed {
		logic [7:0] eventCode;
		logic [7:0] eventSubqualifier;
	} dec_evt_route_t;

	typedef logic [NUM_CTR-1:0][EVT_CNT_W-1:0] dec_evt_cnt_t;

endpackage : dec_pkg

// [dec_event_counter.sv]
`timescale 1ns/1ps
module dec_event_counter (
	// Clock and reset
	input  wire  logic                        clock,
	input  wire  logic                        rstn,
	// Software load
	input  wire  logic                        load,
	input  wire  logic [dec_pkg::LOAD_W-1:0]  loadValue,
	// Increment
	input  wire  logic [dec_pkg::EVT_CNT_W-1:0] step,
	// State
	output dec_pkg::dec_count_t               count,
	output logic                              overflow
);
	import dec_pkg::*;

	logic [CTR_W:0] sum;

	always_comb begin
		sum = {1'b0, count} + {{(CTR_W + 1 - EVT_CNT_W){1'b0}}, step};
	end

	// Counter, load wins over counting
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			count <= CNT_RESET;
		end else if (load) begin
			count <= {{EXT_W{loadValue[SIGN_BIT]}}, loadValue};
		end else begin
			count <= sum[CTR_W-1:0];
		end
	end

	// Carry out of the top bit
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			overflow <= 1'b0;
		end else begin
			overflow <= !load && sum[CTR_W];
		end
	end

endmodule : dec_event_counter

// [dec_unit.sv]
`timescale 1ns/1ps
module dec_unit (
	// Clock and reset
	input  wire  logic                    clock,
	input  wire  logic                    rstn,
	// Model-register access
	input  dec_pkg::dec_msr_req_t         msrReq,
	output dec_pkg::dec_msr_rsp_t         msrRsp_q,
	// Counter-read instruction
	input  dec_pkg::dec_read_req_t        readReq,
	output dec_pkg::dec_read_rsp_t        readRsp_q,
	// Processor state
	input  dec_pkg::dec_priv_t            priv,
	input  wire  logic                    userCounterReadGate,
	// Event sources
	input  dec_pkg::dec_evt_cnt_t         eventCount,
	output dec_pkg::dec_evt_route_t       evtRoute0_q,
	output dec_pkg::dec_evt_route_t       evtRoute1_q,
	// Bus clock marker
	input  wire  logic                    busTick,
	// Monitor pins
	output logic [dec_pkg::NUM_CTR-1:0]   monitorPulsePin_q,
	// Interrupt request
	output logic                          perfIrq_q
);
	import dec_pkg::*;

	dec_evtsel_t                 sel_q [NUM_CTR];
	dec_count_t                  count [NUM_CTR];
	logic [NUM_CTR-1:0]          overflow;
	logic [NUM_CTR-1:0]          cntLoad;
	logic [NUM_CTR-1:0][EVT_CNT_W-1:0] step;
	logic [NUM_CTR-1:0]          prevCond_q;
	logic [NUM_CTR-1:0]          curCond;
	logic [NUM_CTR-1:0]          pinPend_q;
	logic [NUM_CTR-1:0]          pinSet;
	logic                        msrAllowed;
	logic                        msrWriteOk;
	logic                        readAllowed;

	// Privilege level 0 test
	function automatic logic isKernel(input dec_priv_t p);
		isKernel = (p.cpl == CPL_KERNEL);
	endfunction : isKernel

	// Level filter of one select register
	function automatic logic levelOk(input dec_evtsel_t s, input dec_priv_t p);
		levelOk = (s.userLevelQualifier && !isKernel(p))
			|| (s.kernelLevelQualifier && isKernel(p));
	endfunction : levelOk

	// Counter slot addressed by an index
	function automatic logic hitsCounter(input logic [IDX_W-1:0] idx, input int n);
		hitsCounter = (n == 0) ? (idx == IDX_CNT0) : (idx == IDX_CNT1);
	endfunction : hitsCounter

	// Model-register gating
	always_comb begin
		msrAllowed = isKernel(priv);
		msrWriteOk = msrReq.valid && msrReq.write && msrAllowed;
	end

	// Select register 0
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			sel_q[0] <= dec_evtsel_t'(SEL_RESET);
		end else if (msrWriteOk && msrReq.index == IDX_SEL0) begin
			sel_q[0] <= dec_evtsel_t'(msrReq.wdata & SEL0_WMASK);
		end
	end

	// Select register 1, no run bit
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			sel_q[1] <= dec_evtsel_t'(SEL_RESET);
		end else if (msrWriteOk && msrReq.index == IDX_SEL1) begin
			sel_q[1] <= dec_evtsel_t'(msrReq.wdata & SEL1_WMASK);
		end
	end

	// Per-counter datapath
	genvar gi;
	generate
		for (gi = 0; gi < NUM_CTR; gi++) begin : g_ctr
			logic             enable;
			logic             qualify;
			logic [EVT_CNT_W-1:0] raw;
			logic             hit;
			logic [EVT_CNT_W-1:0] level;

			always_comb begin
				cntLoad[gi] = msrWriteOk && hitsCounter(msrReq.index, gi);
			end

			always_comb begin
				enable = sel_q[0].globalRun && (sel_q[gi] != dec_evtsel_t'(SEL_RESET));
				qualify = enable && levelOk(sel_q[gi], priv);
				raw = qualify ? eventCount[gi] : EVT_ZERO;
				hit = (raw >= sel_q[gi].perCycleThreshold) ^ sel_q[gi].compareFlip;
				if (!qualify) begin
					level = EVT_ZERO;
				end else if (sel_q[gi].perCycleThreshold != EVT_ZERO) begin
					level = hit ? EVT_ONE : EVT_ZERO;
				end else begin
					level = raw;
				end
				curCond[gi] = (level != EVT_ZERO);
				if (sel_q[gi].edgeDetect) begin
					step[gi] = (curCond[gi] && !prevCond_q[gi]) ? EVT_ONE : EVT_ZERO;
				end else begin
					step[gi] = level;
				end
			end

			dec_event_counter u_counter (
				.clock     (clock),
				.rstn      (rstn),
				.load      (cntLoad[gi]),
				.loadValue (msrReq.wdata),
				.step      (step[gi]),
				.count     (count[gi]),
				.overflow  (overflow[gi])
			);

			always_comb begin
				if (sel_q[gi].pinModeSelect) begin
					pinSet[gi] = (step[gi] != EVT_ZERO);
				end else begin
					pinSet[gi] = overflow[gi];
				end
			end
		end
	endgenerate

	// Previous qualified condition for edge detection
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			prevCond_q <= '0;
		end else begin
			prevCond_q <= curCond;
		end
	end

	// Pending pulses, a new request wins over the clear
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pinPend_q <= '0;
		end else if (busTick) begin
			pinPend_q <= pinSet;
		end else begin
			pinPend_q <= pinPend_q | pinSet;
		end
	end

	// Pins held for one whole bus clock
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			monitorPulsePin_q <= '0;
		end else if (busTick) begin
			monitorPulsePin_q <= pinPend_q;
		end
	end

	// Overflow interrupt request
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			perfIrq_q <= 1'b0;
		end else begin
			perfIrq_q <= (overflow[0] && sel_q[0].overflowIrqEn)
				|| (overflow[1] && sel_q[1].overflowIrqEn);
		end
	end

	// Model-register answer
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			msrRsp_q <= '0;
		end else begin
			msrRsp_q.done  <= msrReq.valid;
			msrRsp_q.fault <= msrReq.valid && !msrAllowed;
			if (msrReq.valid && !msrReq.write && msrAllowed) begin
				case (msrReq.index)
					IDX_SEL0: msrRsp_q.rdata <= {READ_PAD, sel_q[0]};
					IDX_SEL1: msrRsp_q.rdata <= {READ_PAD, sel_q[1]};
					IDX_CNT0: msrRsp_q.rdata <= count[0];
					IDX_CNT1: msrRsp_q.rdata <= count[1];
					default:  msrRsp_q.rdata <= CNT_RESET;
				endcase
			end else begin
				msrRsp_q.rdata <= CNT_RESET;
			end
		end
	end

	// Counter-read gating
	always_comb begin
		readAllowed = userCounterReadGate || (isKernel(priv) && !priv.v86);
	end

	// Counter-read answer, sampled at once
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			readRsp_q <= '0;
		end else begin
			readRsp_q.done  <= readReq.valid;
			readRsp_q.fault <= readReq.valid && !readAllowed;
			if (readReq.valid && readAllowed) begin
				readRsp_q.data <= count[readReq.index];
			end else begin
				readRsp_q.data <= CNT_RESET;
			end
		end
	end

	// Event routing to the sources
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			evtRoute0_q <= '0;
			evtRoute1_q <= '0;
		end else begin
			evtRoute0_q.eventCode         <= sel_q[0].eventCode;
			evtRoute0_q.eventSubqualifier <= sel_q[0].eventSubqualifier;
			evtRoute1_q.eventCode         <= sel_q[1].eventCode;
			evtRoute1_q.eventSubqualifier <= sel_q[1].eventSubqualifier;
		end
	end

endmodule : dec_unit

// [dec_unit_props.sv]
`timescale 1ns/1ps
module dec_unit_props (
	// Clock and reset
	input wire logic                        clock,
	input wire logic                        rstn,
	// Requests and answers
	input dec_pkg::dec_msr_req_t            msrReq,
	input dec_pkg::dec_msr_rsp_t            msrRsp_q,
	input dec_pkg::dec_read_req_t           readReq,
	input dec_pkg::dec_read_rsp_t           readRsp_q,
	input dec_pkg::dec_priv_t               priv,
	input wire logic                        userCounterReadGate,
	// Outputs and the bus clock marker
	input dec_pkg::dec_evt_route_t          evtRoute0_q,
	input wire logic                        busTick,
	input wire logic [dec_pkg::NUM_CTR-1:0] monitorPulsePin_q,
	input wire logic                        perfIrq_q
);
	import dec_pkg::*;
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	a_msr_answer: assert property (msrReq.valid |=> msrRsp_q.done)
		else $error("msr answer missing");
	a_msr_refuse: assert property (msrReq.valid && priv.cpl != CPL_KERNEL
		|=> msrRsp_q.fault && msrRsp_q.rdata == '0) else $error("msr not refused");
	a_read_refuse: assert property (readReq.valid && !userCounterReadGate
		&& (priv.cpl != CPL_KERNEL || priv.v86) |=> readRsp_q.done && readRsp_q.fault)
		else $error("read not refused");
	a_read_open: assert property (readReq.valid && userCounterReadGate
		|=> readRsp_q.done && !readRsp_q.fault) else $error("open read refused");
	a_read_idle: assert property (!readReq.valid |=> !readRsp_q.done)
		else $error("spurious read answer");
	a_route_copy: assert property (msrReq.valid && msrReq.write && msrReq.index == IDX_SEL0
		&& priv.cpl == CPL_KERNEL |-> ##2 evtRoute0_q == {$past(msrReq.wdata[7:0], 2),
		$past(msrReq.wdata[15:8], 2)}) else $error("route not copied");
	a_pin_on_tick: assert property ($changed(monitorPulsePin_q) |-> $past(busTick))
		else $error("pin moved off bus clock");
	a_irq_pulse: assert property (perfIrq_q |=> !perfIrq_q)
		else $error("irq longer than one cycle");
	c_irq: cover property (perfIrq_q);
	c_pin: cover property (|monitorPulsePin_q);
	c_refuse: cover property (msrRsp_q.fault);
endmodule : dec_unit_props

bind dec_unit dec_unit_props u_props (.clock, .rstn, .msrReq, .msrRsp_q, .readReq, .readRsp_q,
	.priv, .userCounterReadGate, .evtRoute0_q, .busTick, .monitorPulsePin_q, .perfIrq_q);

// [dec_far_model.sv]
`timescale 1ns/1ps
module dec_far_model (
	// Clock and reset
	input wire logic                        clock,
	input wire logic                        rstn,
	// Device side
	input wire logic [dec_pkg::NUM_CTR-1:0] monitorPulsePin_q,
	input wire logic                        perfIrq_q,
	output logic                            busTick,
	// Tallies
	output int                              pinSeen,
	output int                              pin1Seen,
	output int                              irqSeen
);
	import dec_pkg::*;
	logic [1:0] div_q;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) div_q <= 2'h0;
		else div_q <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
	end
	assign busTick = div_q == 2'h2;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pinSeen <= 0;
			pin1Seen <= 0;
			irqSeen <= 0;
		end else begin
			if (busTick && monitorPulsePin_q[0]) pinSeen <= pinSeen + 1;
			if (busTick && monitorPulsePin_q[1]) pin1Seen <= pin1Seen + 1;
			if (perfIrq_q) irqSeen <= irqSeen + 1;
		end
	end
endmodule : dec_far_model

// [dec_unit_test.sv]
`timescale 1ns/1ps
module dec_unit_test;
	import dec_pkg::*;
	typedef struct packed {
		logic [31:0] sel;
		logic [1:0]  cpl;
		logic [7:0]  evt;
		dec_count_t  exp;
	} dec_row_t;
	logic               clock = 1'b0;
	logic               rstn = 1'b0;
	dec_msr_req_t       msrReq = '0;
	dec_msr_rsp_t       msrRsp_q;
	dec_read_req_t      readReq = '0;
	dec_read_rsp_t      readRsp_q;
	dec_priv_t          priv = '0;
	logic               gate = 1'b0;
	dec_evt_cnt_t       eventCount = '0;
	logic               busTick;
	logic [NUM_CTR-1:0] pins;
	logic               irq;
	int                 pinSeen, irqSeen, pin1Seen;
	dec_evt_route_t     route0, route1;
	int                 n_mismatch = 0;
	int                 checks = 0;
	dec_count_t         r;
	dec_row_t rows [9] = '{'{32'h00420001, 2'h0, 8'h03, 40'hC},
		'{32'h02420001, 2'h0, 8'h03, 40'h4}, '{32'h02420001, 2'h0, 8'h01, 40'h0},
		'{32'h03C20001, 2'h0, 8'h01, 40'h7}, '{32'h00410001, 2'h3, 8'h02, 40'h8},
		'{32'h00410001, 2'h0, 8'h02, 40'h0}, '{32'h00420001, 2'h3, 8'h02, 40'h0},
		'{32'h00460001, 2'h0, 8'h01, 40'h1}, '{32'h00020001, 2'h0, 8'h01, 40'h0}};
	always #50 clock = ~clock;
	dec_unit dut (.clock, .rstn, .msrReq, .msrRsp_q, .readReq, .readRsp_q, .priv,
		.userCounterReadGate(gate), .eventCount, .evtRoute0_q(route0), .evtRoute1_q(route1),
		.busTick,
		.monitorPulsePin_q(pins), .perfIrq_q(irq));
	dec_far_model far (.clock, .rstn, .monitorPulsePin_q(pins), .perfIrq_q(irq), .busTick,
		.pinSeen, .irqSeen, .pin1Seen);
	task automatic chk(input string nm, input dec_count_t seen, input dec_count_t want);
		checks++;
		if (seen !== want) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, want, seen);
		end
	endtask : chk
	task automatic wrap_up;
		if (n_mismatch == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : wrap_up
	task automatic msr(input logic w, input logic [1:0] i, input logic [31:0] d, input logic f);
		@(posedge clock);
		msrReq <= '{1'b1, w, i, d};
		@(posedge clock);
		msrReq <= '0;
		#1;
		r = msrRsp_q.rdata;
		chk("msr ack", dec_count_t'({msrRsp_q.done, msrRsp_q.fault}), dec_count_t'({1'b1, f}));
	endtask : msr
	task automatic cread(input logic i, input logic f);
		@(posedge clock);
		readReq <= '{1'b1, i};
		@(posedge clock);
		readReq <= '0;
		#1;
		r = readRsp_q.data;
		chk("read ack", dec_count_t'({readRsp_q.done, readRsp_q.fault}), dec_count_t'({1'b1, f}));
	endtask : cread
	initial begin
		repeat (20000) @(posedge clock);
		n_mismatch++;
		wrap_up;
	end
	initial begin
		repeat (16) @(posedge clock);
		rstn <= 1'b1;
		msr(1'b0, IDX_SEL0, '0, 1'b0);
		chk("sel0 reset", r, dec_count_t'(SEL_RESET));
		msr(1'b0, IDX_CNT1, '0, 1'b0);
		chk("cnt1 reset", r, CNT_RESET);
		msr(1'b1, IDX_CNT1, 32'h80000005, 1'b0);
		msr(1'b0, IDX_CNT1, '0, 1'b0);
		chk("cnt1 load", r, 40'hFF80000005);
		msr(1'b1, IDX_CNT0, 32'h7FFFFFFF, 1'b0);
		msr(1'b0, IDX_CNT0, '0, 1'b0);
		chk("cnt0 load", r, 40'h007FFFFFFF);
		msr(1'b1, IDX_SEL1, 32'hFFFFFFFF, 1'b0);
		msr(1'b0, IDX_SEL1, '0, 1'b0);
		chk("sel1 bits", r, 40'h00FF9FFFFF);
		chk("route1", dec_count_t'(route1), 40'hFFFF);
		msr(1'b1, IDX_SEL1, '0, 1'b0);
		@(posedge clock);
		priv.cpl <= 2'h3;
		msr(1'b1, IDX_SEL0, 32'h00420001, 1'b1);
		@(posedge clock);
		priv.cpl <= 2'h0;
		msr(1'b0, IDX_SEL0, '0, 1'b0);
		chk("sel0 kept", r, 40'h0);
		for (int k = 0; k < 8; k++) begin
			@(posedge clock);
			gate <= k[0];
			priv <= '{k[1] ? 2'h3 : 2'h0, k[2]};
			cread(1'b1, !k[0] && (k[1] || k[2]));
			chk("read data", r, (k[0] || !(k[1] || k[2])) ? 40'hFF80000005 : 40'h0);
		end
		@(posedge clock);
		priv <= '0;
		gate <= 1'b0;
		foreach (rows[j]) begin
			msr(1'b1, IDX_CNT0, '0, 1'b0);
			msr(1'b1, IDX_SEL0, rows[j].sel, 1'b0);
			@(posedge clock);
			priv.cpl <= rows[j].cpl;
			eventCount[0] <= rows[j].evt;
			repeat (4) @(posedge clock);
			priv.cpl <= 2'h0;
			eventCount[0] <= 8'h00;
			msr(1'b1, IDX_SEL0, '0, 1'b0);
			msr(1'b0, IDX_CNT0, '0, 1'b0);
			chk("row count", r, rows[j].exp);
		end
		msr(1'b1, IDX_CNT0, 32'hFFFFFFFE, 1'b0);
		msr(1'b1, IDX_SEL0, 32'h00520001, 1'b0);
		@(posedge clock);
		eventCount[0] <= 8'h01;
		repeat (4) @(posedge clock);
		eventCount[0] <= 8'h00;
		repeat (10) @(posedge clock);
		msr(1'b1, IDX_SEL0, '0, 1'b0);
		msr(1'b0, IDX_CNT0, '0, 1'b0);
		chk("wrap count", r, 40'h2);
		chk("irq pulses", dec_count_t'(irqSeen), 40'h1);
		chk("pin overflow", dec_count_t'(pinSeen), 40'h1);
		msr(1'b1, IDX_SEL0, 32'h004A2301, 1'b0);
		@(posedge clock);
		eventCount[0] <= 8'h01;
		@(posedge clock);
		eventCount[0] <= 8'h00;
		repeat (10) @(posedge clock);
		chk("pin event", dec_count_t'(pinSeen), 40'h2);
		chk("route0", dec_count_t'(route0), 40'h0123);
		msr(1'b1, IDX_CNT0, '0, 1'b0);
		msr(1'b1, IDX_CNT1, '0, 1'b0);
		msr(1'b1, IDX_SEL1, 32'h000A0001, 1'b0);
		for (int p = 0; p < 2; p++) begin
			@(posedge clock);
			eventCount <= {8'h01, 8'h01};
			@(posedge clock);
			eventCount <= '0;
			msr(1'b1, IDX_SEL1, '0, 1'b0);
		end
		repeat (10) @(posedge clock);
		msr(1'b0, IDX_CNT1, '0, 1'b0);
		chk("cnt1 stopped", r, 40'h1);
		msr(1'b0, IDX_CNT0, '0, 1'b0);
		chk("cnt0 running", r, 40'h2);
		chk("pin per event", dec_count_t'(pinSeen), 40'h4);
		chk("pin1 event", dec_count_t'(pin1Seen), 40'h1);
		@(posedge clock);
		rstn <= 1'b0;
		repeat (2) @(posedge clock);
		rstn <= 1'b1;
		msr(1'b0, IDX_SEL0, '0, 1'b0);
		chk("sel0 after reset", r, dec_count_t'(SEL_RESET));
		msr(1'b0, IDX_CNT1, '0, 1'b0);
		chk("cnt1 after reset", r, CNT_RESET);
		chk("pins after reset", dec_count_t'(pins), 40'h0);
		wrap_up;
	end
endmodule : dec_unit_test
